// >>> bench/bus_master.sv
// Behavioural I2C bus master for the paged register slave.
// Assumes a pull-up on SDA; the bench calls its tasks at falling edges.
`timescale 1ns/10ps

module bus_master
(
  input wire logic ref_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sdaDrv = 1'b1;
  logic spike = 1'b0;

  initial sclIn = 1'b1;
  // Open drain data wire with pull-up
  assign sdaIn = sdaDrv & ~sdaOe;

  task automatic hold(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One bit: SCL low 1 us, data sampled mid-high
  task automatic bitx(input logic b, output logic r);
    sdaDrv = b;
    hold(25);
    if (spike)
    begin
      sclIn = 1'b1;
      hold(5);
      sclIn = 1'b0;
    end
    hold(25);
    sclIn = 1'b1;
    hold(25);
    r = sdaIn;
    hold(25);
    sclIn = 1'b0;
    hold(50);
  endtask

  task automatic start();
    sdaDrv = 1'b1;
    hold(50);
    sclIn = 1'b1;
    hold(50);
    sdaDrv = 1'b0;
    hold(50);
    sclIn = 1'b0;
    hold(50);
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    hold(50);
    sclIn = 1'b1;
    hold(50);
    sdaDrv = 1'b1;
    hold(100);
  endtask

  // Whole byte, MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ackIn, a);
    ack = ~a;
  endtask
endmodule

// >>> bench/slave_checker.sv
// Port-level assertions for the paged register slave.
// Assumes bind onto the top module; one clock, synchronous reset.
`timescale 1ns/10ps

module slave_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [7:0] activePage,
  input wire logic [15:0] firstDigitalPllPriority
);
  logic sclQ;
  logic sdaQ;
  logic [3:0] riseCnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // SCL rises since the last START
  always_ff @(posedge ref_clk)
  begin
    sclQ <= sclIn;
    sdaQ <= sdaIn;
    if (rst || (sclIn && sclQ && sdaQ && !sdaIn))
      riseCnt <= 4'h0;
    else if (sclIn && !sclQ && riseCnt != 4'hF)
      riseCnt <= riseCnt + 4'h1;
  end

  oe_reset_a: assert property (disable iff (1'b0) rst |=> !sdaOe
    && activePage == 8'h00 && firstDigitalPllPriority == 16'h0000)
    else $error("state not cleared by reset");
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  oe_scl_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("SDA drive changed with SCL high");
  oe_hold_a: assert property ($rose(sdaOe) |=> sdaOe [*8])
    else $error("SDA drive too short");
  page_scl_low_a: assert property ($changed(activePage) |-> !sclIn)
    else $error("page changed outside a write");
  prio_scl_low_a: assert property
    ($changed(firstDigitalPllPriority) |-> !sclIn)
    else $error("priority changed outside a write");
  prio_page_a: assert property
    ($changed(firstDigitalPllPriority) |-> activePage == 8'h02)
    else $error("priority changed from wrong page");
  addr_quiet_a: assert property (riseCnt < 4'h8 |-> !sdaOe)
    else $error("SDA driven during address");
endmodule

bind i2c_paged_register_slave slave_checker u_slave_checker (
  .ref_clk(ref_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .activePage(activePage),
  .firstDigitalPllPriority(firstDigitalPllPriority));

// >>> bench/tb_top.sv
// Self-checking bench for the paged register slave.
// Assumes the bus master model and checker are compiled first.
`timescale 1ns/10ps
`include "i2c_slave_regs.svh"

module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] strap = 3'h5;
  logic [2:0] tgt = 3'h5;
  logic sclIn, sdaIn, sdaOut, sdaOe, ak;
  logic [7:0] activePage, q;
  logic [15:0] firstDigitalPllPriority;
  int err_total = 0;
  int n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  i2c_paged_register_slave u_i2c_paged_register_slave (.ref_clk(ref_clk),
    .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .slave_addr_strap_bit0(strap[0]), .slave_addr_strap_bit1(strap[1]),
    .slave_addr_strap_bit2(strap[2]), .activePage(activePage),
    .firstDigitalPllPriority(firstDigitalPllPriority));
  bus_master u_bus_master (.ref_clk(ref_clk), .sdaOe(sdaOe),
    .sclIn(sclIn), .sdaIn(sdaIn));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic head(input logic rd, input logic expAck);
    u_bus_master.start();
    u_bus_master.xfer({`SLAVE_ADDR_HIGH, tgt, rd}, 1'b1, q, ak);
    chk(ak, expAck);
  endtask

  task automatic wr(input logic [7:0] off, input logic [15:0] d, input int n);
    head(1'b0, 1'b1);
    u_bus_master.xfer(off, 1'b1, q, ak);
    for (int i = 0; i < n; i++)
      u_bus_master.xfer(d[8*i +: 8], 1'b1, q, ak);
    chk(ak, 1'b1);
    u_bus_master.stop();
  endtask

  task automatic rd(input logic sq, input logic [7:0] off,
                    input logic [23:0] e, input int n);
    if (sq)
    begin
      head(1'b0, 1'b1);
      u_bus_master.xfer(off, 1'b1, q, ak);
    end
    head(1'b1, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_bus_master.xfer(8'hFF, i == n - 1, q, ak);
      chk(q, e[8*i +: 8]);
    end
    u_bus_master.stop();
  endtask

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    chk(activePage, 8'h00);
    chk(firstDigitalPllPriority, 16'h0000);
    u_bus_master.hold(10);
    wr(8'h00, 16'hC35A, 2);
    wr(8'h00, 16'h005A, 1);
    rd(1'b0, 8'h00, 24'h0000C3, 1);
    rd(1'b1, 8'hFF, 24'hC35A00, 3);
    u_bus_master.spike = 1'b1;
    wr(8'h7F, 16'h0002, 1);
    u_bus_master.spike = 1'b0;
    chk(activePage, 8'h02);
    rd(1'b1, 8'h7F, 24'h000002, 1);
    wr(8'h00, 16'h0034, 1);
    chk(firstDigitalPllPriority, 16'h0000);
    wr(8'h01, 16'h0012, 1);
    chk(firstDigitalPllPriority, 16'h1234);
    rd(1'b1, 8'h00, 24'h001234, 2);
    tgt = 3'h2;
    head(1'b0, 1'b0);
    u_bus_master.stop();
    strap = 3'h2;
    wr(8'h7F, 16'h0000, 1);
    chk(activePage, 8'h00);
    rd(1'b1, 8'h01, 24'h0000C3, 1);
    summarize();
  end
endmodule

// >>> core/i2c_line_if.sv
// Carrier between the slave core and its bus line filter.
// Raw lines go in, spike-free lines come back.
`timescale 1ns/10ps

interface i2c_line_if;
  logic sclRaw;
  logic sdaRaw;
  logic sclClean;
  logic sdaClean;

  modport filter (input sclRaw, input sdaRaw,
                  output sclClean, output sdaClean);
  modport core (output sclRaw, output sdaRaw,
                input sclClean, input sdaClean);
endinterface

// >>> core/i2c_paged_pkg.sv
// Types shared by the paged I2C register slave and its line filter.
// Assumes the constants header is on the include path.
`include "i2c_slave_regs.svh"

package i2c_paged_pkg;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h0,
    PH_ADDR = 4'h1,
    PH_ADDR_ACK = 4'h2,
    PH_OFFS = 4'h3,
    PH_OFFS_ACK = 4'h4,
    PH_WDATA = 4'h5,
    PH_WACK = 4'h6,
    PH_RDATA = 4'h7,
    PH_MACK = 4'h8
  } phase_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0][2:0] cnt;
  } filter_state_t;

  typedef struct packed {
    phase_t phase;
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic isRead;
    logic drive;
    logic [7:0] offset;
    logic [7:0] page;
    logic [7:0] stageLow;
    logic [7:0] snapHigh;
    logic [15:0] prioTable;
    logic [`SCRATCH_DEPTH-1:0][7:0] mem;
  } slave_state_t;

endpackage

// >>> core/i2c_paged_register_slave.sv
// Paged register slave reached over I2C by an external bus master.
// Assumes SCL and SDA inputs synchronous to ref_clk; SDA is open drain,
// the pad pulls low while sdaOe is high. SCL is never stretched.
`timescale 1ns/10ps
`include "i2c_slave_regs.svh"

module i2c_paged_register_slave
  import i2c_paged_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic slave_addr_strap_bit0,
  input wire logic slave_addr_strap_bit1,
  input wire logic slave_addr_strap_bit2,
  output logic [7:0] activePage,
  output logic [15:0] firstDigitalPllPriority
);

  slave_state_t s;
  slave_state_t next_s;
  i2c_line_if lines ();
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [6:0] ownAddr;
  logic [7:0] rxByte;

  // Line filtering
  assign lines.sclRaw = sclIn;
  assign lines.sdaRaw = sdaIn;

  i2c_spike_filter u_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .lines(lines)
  );

  // Bus events from the filtered lines
  assign sclRise = lines.sclClean & ~s.sclQ;
  assign sclFall = ~lines.sclClean & s.sclQ;
  assign startSeen = lines.sclClean & s.sclQ & s.sdaQ & ~lines.sdaClean;
  assign stopSeen = lines.sclClean & s.sclQ & ~s.sdaQ & lines.sdaClean;
  assign rxByte = s.shiftReg;

  // Own address: fixed high nibble and three straps
  assign ownAddr = {`SLAVE_ADDR_HIGH, slave_addr_strap_bit2,
                    slave_addr_strap_bit1, slave_addr_strap_bit0}; // [R12]

  // Byte returned for an offset within the active page
  function automatic logic [7:0] readByte(input slave_state_t st);
    logic [7:0] val;
    val = 8'h00;
    if (st.offset == `PAGE_PTR_OFFSET)
      val = st.page; // [R5]
    else if (st.page == `PRIO_PAGE && st.offset == `PRIO_LOW_OFFSET)
      val = st.prioTable[7:0];
    else if (st.page == `PRIO_PAGE && st.offset == `PRIO_HIGH_OFFSET)
      val = st.snapHigh; // [R13]
    else if (st.offset[7:4] == 4'h0)
      val = st.mem[st.offset[3:0]];
    return val;
  endfunction

  // Transaction sequencing, register writes and reads
  always_comb
  begin
    next_s = s;
    next_s.sclQ = lines.sclClean;
    next_s.sdaQ = lines.sdaClean;
    if (startSeen)
    begin
      next_s.phase = PH_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.drive = 1'b0;
    end
    else if (stopSeen)
    begin
      next_s.phase = PH_IDLE;
      next_s.drive = 1'b0;
    end
    else if (sclRise)
    begin
      case (s.phase)
        PH_ADDR, PH_OFFS, PH_WDATA:
        begin
          // Receive one bit, MSB first, as 8-bit cycles
          next_s.shiftReg = {s.shiftReg[6:0], lines.sdaClean}; // [R6]
          next_s.bitCnt = s.bitCnt + 4'h1;
        end
        PH_MACK:
        begin
          // Master not acknowledging ends the burst
          if (lines.sdaClean)
            next_s.phase = PH_IDLE;
        end
        default:
        begin
          next_s.phase = s.phase;
        end
      endcase
    end
    else if (sclFall)
    begin
      case (s.phase)
        PH_ADDR:
        begin
          if (s.bitCnt == 4'h8)
          begin
            if (rxByte[7:1] == ownAddr) // [R12]
            begin
              next_s.drive = 1'b1;
              next_s.isRead = rxByte[0];
              next_s.phase = PH_ADDR_ACK;
            end
            else
              next_s.phase = PH_IDLE;
          end
        end
        PH_ADDR_ACK:
        begin
          next_s.bitCnt = 4'h0;
          if (s.isRead)
          begin
            // First byte comes from the held next address
            next_s.shiftReg = readByte(s); // [R1]
            next_s.drive = ~next_s.shiftReg[7];
            next_s.offset = s.offset + 8'h01; // [R2]
            if (s.page == `PRIO_PAGE && s.offset == `PRIO_LOW_OFFSET)
              next_s.snapHigh = s.prioTable[15:8]; // [R13]
            next_s.phase = PH_RDATA;
          end
          else
          begin
            next_s.drive = 1'b0;
            next_s.phase = PH_OFFS;
          end
        end
        PH_OFFS:
        begin
          if (s.bitCnt == 4'h8)
          begin
            // Starting offset for a following write or read
            next_s.offset = rxByte; // [R3] [R4]
            next_s.drive = 1'b1;
            next_s.phase = PH_OFFS_ACK;
          end
        end
        PH_OFFS_ACK, PH_WACK:
        begin
          next_s.drive = 1'b0;
          next_s.bitCnt = 4'h0;
          next_s.phase = PH_WDATA;
        end
        PH_WDATA:
        begin
          if (s.bitCnt == 4'h8)
          begin
            next_s.drive = 1'b1;
            next_s.phase = PH_WACK;
            next_s.offset = s.offset + 8'h01; // [R4] [R2]
            if (s.offset == `PAGE_PTR_OFFSET)
              next_s.page = rxByte; // [R7]
            else if (s.page == `PRIO_PAGE &&
                     s.offset == `PRIO_LOW_OFFSET)
              next_s.stageLow = rxByte; // [R8]
            else if (s.page == `PRIO_PAGE &&
                     s.offset == `PRIO_HIGH_OFFSET)
              next_s.prioTable = {rxByte, s.stageLow}; // [R8]
            else if (s.offset[7:4] == 4'h0)
              next_s.mem[s.offset[3:0]] = rxByte;
          end
        end
        PH_RDATA:
        begin
          if (s.bitCnt == 4'h7)
          begin
            // Release SDA for the master's acknowledge
            next_s.drive = 1'b0;
            next_s.phase = PH_MACK;
          end
          else
          begin
            next_s.shiftReg = {s.shiftReg[6:0], 1'b0};
            next_s.drive = ~s.shiftReg[6];
            next_s.bitCnt = s.bitCnt + 4'h1;
          end
        end
        PH_MACK:
        begin
          // Acknowledged: next byte of the burst
          next_s.bitCnt = 4'h0;
          next_s.shiftReg = readByte(s); // [R3]
          next_s.drive = ~next_s.shiftReg[7];
          next_s.offset = s.offset + 8'h01; // [R2]
          if (s.page == `PRIO_PAGE && s.offset == `PRIO_LOW_OFFSET)
            next_s.snapHigh = s.prioTable[15:8]; // [R13]
          next_s.phase = PH_RDATA;
        end
        default:
        begin
          next_s.phase = s.phase;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s.phase <= PH_IDLE;
      s.sclQ <= 1'b1;
      s.sdaQ <= 1'b1;
      s.bitCnt <= 4'h0;
      s.shiftReg <= 8'h00;
      s.isRead <= 1'b0;
      s.drive <= 1'b0;
      s.offset <= 8'h00;
      s.page <= `PAGE_RESET;
      s.stageLow <= 8'h00;
      s.snapHigh <= 8'h00;
      s.prioTable <= `PRIO_RESET;
      s.mem <= '0;
    end
    else
      s <= next_s;
  end

  // Open-drain SDA and register views
  assign sdaOut = 1'b0;
  assign sdaOe = s.drive;
  assign activePage = s.page;
  assign firstDigitalPllPriority = s.prioTable;

endmodule

// >>> core/i2c_slave_regs.svh
// Constants of the paged I2C register slave: offsets, reset values, timing.
// Assumes a 100 MHz ref_clk; included by the package and the design files.
//
// Overview of operation
// (R1) Offsetless read starts one past last address
// (R2) Burst address wraps from top to zero
// (R3) Sequential read: offset given, then incrementing burst
// (R4) Sequential write: offset given, bytes stored incrementing
// (R5) 128-byte pages, page pointer at 0x7F
// (R6) 8-bit cycles; offset selects byte in page
// (R7) Writing 0x7F makes that page active
// (R8) Multi-byte write applies only after last byte
// (R9) Master reads multi-byte registers low byte first
// (R10) Master never interleaves inside multi-byte access
// (R11) Input filter rejects spikes up to 50 ns
// (R12) Slave address is 1010 plus three straps
// (R13) Low-byte read snapshots whole multi-byte register
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH

`define SLAVE_ADDR_HIGH 4'hA
`define PAGE_BYTES 128
`define PAGE_PTR_OFFSET 8'h7F
`define PAGE_RESET 8'h00
`define PRIO_PAGE 8'h02
`define PRIO_LOW_OFFSET 8'h00
`define PRIO_HIGH_OFFSET 8'h01
`define PRIO_RESET 16'h0000
`define SCRATCH_DEPTH 16
`define SPIKE_NS 50
`define CLK_PERIOD_NS 10
// Longest rejected spike in cycles, rounded down
`define SPIKE_CYCLES (`SPIKE_NS / `CLK_PERIOD_NS)
// Level must hold one cycle longer than a spike to be taken
`define FILTER_ACCEPT 3'(`SPIKE_CYCLES)

`endif

// >>> core/i2c_spike_filter.sv
// Glitch filter for SCL and SDA, one counter per line.
// Assumes raw lines synchronous to ref_clk; idle level is high.
`timescale 1ns/10ps

module i2c_spike_filter
  import i2c_paged_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  i2c_line_if.filter lines
);

  filter_state_t s;
  filter_state_t next_s;
  logic [1:0] raw;

  assign raw = {lines.sclRaw, lines.sdaRaw};

  // A change is taken only after it outlasts the longest spike
  always_comb
  begin
    next_s = s;
    for (int i = 0; i < 2; i++)
    begin
      if (raw[i] == s.level[i])
        next_s.cnt[i] = 3'h0;
      else if (s.cnt[i] == `FILTER_ACCEPT) // [R11]
      begin
        next_s.level[i] = raw[i];
        next_s.cnt[i] = 3'h0;
      end
      else
        next_s.cnt[i] = s.cnt[i] + 3'h1;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s.level <= 2'h3;
      s.cnt <= '0;
    end
    else
      s <= next_s;
  end

  assign lines.sclClean = s.level[1];
  assign lines.sdaClean = s.level[0];

endmodule
